//--- misc_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module misc_status_config_regs #(
   parameter logic [4:0] VARIANT_CODE = 5'h1F  // Arbitrary value.
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // Register access port from the serial control logic.
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [11:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // Status from the device.
   input  wire logic        init_done_in,
   // Controls to the datapath.
   output logic      [15:0] nco_phase_chan_b_preset3,
   output logic             digital_rail_quieting,
   output logic             clock_rail_quieting,
   output logic             cal_start,
   output logic             auto_delay_select
);
   logic [15:0] phase;
   logic [1:0]  noise;
   logic        cal_en;
   logic        init_meta;
   logic        init_sync;
   logic [15:0] next_rdata;

   // Both quieting bits come back on at reset, since quiet rails are the safe default.
   localparam logic [1:0]  NOISE_RESET  = {
      misc_regs_pkg::SUPPLY_NOISE_RESET[misc_regs_pkg::DIGITAL_QUIET_BIT],
      misc_regs_pkg::SUPPLY_NOISE_RESET[misc_regs_pkg::CLOCK_QUIET_BIT]
   };
   localparam logic [15:0] DIGITAL_MASK = 16'h0001 << misc_regs_pkg::DIGITAL_QUIET_BIT;
   localparam logic [15:0] CLOCK_MASK   = 16'h0001 << misc_regs_pkg::CLOCK_QUIET_BIT;
   localparam logic        CAL_RESET    =
      misc_regs_pkg::SYSREF_CAL_RESET[misc_regs_pkg::CAL_ENABLE_BIT];

   wire hit_phase = reg_addr == misc_regs_pkg::NCO_PHASE_B3_ADDR;
   wire hit_init  = reg_addr == misc_regs_pkg::STARTUP_STATE_ADDR;
   wire hit_var   = reg_addr == misc_regs_pkg::SILICON_VAR_ADDR;
   wire hit_noise = reg_addr == misc_regs_pkg::SUPPLY_NOISE_ADDR;
   wire hit_cal   = reg_addr == misc_regs_pkg::SYSREF_CAL_EN_ADDR;
   wire hit_any   = hit_phase | hit_init | hit_var | hit_noise | hit_cal;

   // The two read-only offsets get no write strobe, so a write there cannot disturb them.
   wire wr_phase  = reg_wr & hit_phase;
   wire wr_noise  = reg_wr & hit_noise;
   wire wr_cal    = reg_wr & hit_cal;

   wire next_digital_quiet = reg_wdata[misc_regs_pkg::DIGITAL_QUIET_BIT];
   wire next_clock_quiet   = reg_wdata[misc_regs_pkg::CLOCK_QUIET_BIT];
   wire next_cal_en        = reg_wdata[misc_regs_pkg::CAL_ENABLE_BIT];

   // Read words; every bit that no field owns is tied to zero.
   wire [15:0] word_phase = hit_phase ? phase : 16'h0000;
   wire [15:0] word_init  = hit_init ? {15'h0000, init_sync} : 16'h0000;
   wire [15:0] word_var   = hit_var ? {11'h000, VARIANT_CODE} : 16'h0000;
   wire [15:0] word_noise = hit_noise ? ((noise[1] ? DIGITAL_MASK : 16'h0000)
                            | (noise[0] ? CLOCK_MASK : 16'h0000)) : 16'h0000;
   wire [15:0] word_cal   = hit_cal ? {15'h0000, cal_en} : 16'h0000;

   // Initialization done comes from another domain, so it is synchronised first.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         init_meta <= 1'b0;
         init_sync <= 1'b0;
      end else begin
         init_meta <= init_done_in;
         init_sync <= init_meta;
      end
   end

   // Reserved bits are not stored, so writes to them have no effect.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase <= misc_regs_pkg::NCO_PHASE_RESET;
      end else if (wr_phase) begin
         phase <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         noise <= NOISE_RESET;
      end else if (wr_noise) begin
         noise <= {next_digital_quiet, next_clock_quiet};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cal_en <= CAL_RESET;
      end else if (wr_cal) begin
         cal_en <= next_cal_en;
      end
   end

   assign nco_phase_chan_b_preset3 = phase;
   assign digital_rail_quieting = noise[1];
   assign clock_rail_quieting = noise[0];
   assign auto_delay_select = cal_en;

   rise_detect u_rise (
      .clk   (clk),
      .rstn  (rstn),
      .level (cal_en),
      .rise  (cal_start)
   );

   assign next_rdata = word_phase | word_init | word_var | word_noise | word_cal;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // Register behaviour as seen from the bus; everything here lives on the one clock.
   phase_write_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_wr && hit_phase |=> phase == $past(reg_wdata))
      else $error("phase not written");
   phase_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !wr_phase |=> $stable(phase))
      else $error("phase changed without write");
   phase_read_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_phase |=> reg_rdata == $past(phase))
      else $error("phase read wrong");
   init_read_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_init && !init_sync |=> reg_rdata == 16'h0000)
      else $error("init read early");
   init_follow_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_init |=> reg_rdata == {15'h0000, $past(init_sync)})
      else $error("init read wrong");
   init_lag_a: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(init_sync) |-> $past(init_done_in, 2))
      else $error("init flag rose without input");
   variant_ro_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_var |=> reg_rdata[4:0] == VARIANT_CODE)
      else $error("variant wrong");
   rdata_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   digital_quiet_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_wr && hit_noise |=> digital_rail_quieting == $past(reg_wdata[5]))
      else $error("digital quiet");
   clock_quiet_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_wr && hit_noise |=> clock_rail_quieting == $past(reg_wdata[4]))
      else $error("clock quiet");
   noise_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !wr_noise |=> $stable(noise))
      else $error("quieting changed without write");
   noise_read_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_noise |=>
      reg_rdata[misc_regs_pkg::DIGITAL_QUIET_BIT] == $past(digital_rail_quieting) &&
      reg_rdata[misc_regs_pkg::CLOCK_QUIET_BIT] == $past(clock_rail_quieting))
      else $error("quieting read wrong");
   cal_write_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_wr && hit_cal |=> auto_delay_select == $past(reg_wdata[0]))
      else $error("cal enable");
   cal_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !wr_cal |=> $stable(cal_en))
      else $error("cal enable changed without write");
   cal_read_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_cal |=> reg_rdata == {15'h0000, $past(auto_delay_select)})
      else $error("cal enable read wrong");
   cal_start_a: assert property (
      @(posedge clk) disable iff (!rstn)
      cal_start |-> auto_delay_select && !$past(auto_delay_select))
      else $error("bad start");
   cal_single_a: assert property (
      @(posedge clk) disable iff (!rstn)
      cal_start |=> !cal_start)
      else $error("start not one cycle");
   start_rise_a: assert property (
      @(posedge clk) disable iff (!rstn)
      wr_cal && next_cal_en && !cal_en |=> cal_start)
      else $error("start missing on rise");
   manual_quiet_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !auto_delay_select |-> !cal_start)
      else $error("start in manual mode");
   reserved_rd_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && hit_noise |=> reg_rdata[3:0] == 4'h0 && reg_rdata[15:6] == 10'h000)
      else $error("reserved bits set");
   unmapped_rd_a: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_rd && !hit_any |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- misc_regs_pkg.sv
`default_nettype none
package misc_regs_pkg;
   localparam logic [11:0] NCO_PHASE_B3_ADDR   = 12'h25C;
   localparam logic [11:0] STARTUP_STATE_ADDR  = 12'h270;
   localparam logic [11:0] SILICON_VAR_ADDR    = 12'h297;
   localparam logic [11:0] SUPPLY_NOISE_ADDR   = 12'h2A2;
   localparam logic [11:0] SYSREF_CAL_EN_ADDR  = 12'h2B0;
   localparam logic [15:0] NCO_PHASE_RESET     = 16'h0000;
   localparam logic [7:0]  SUPPLY_NOISE_RESET  = 8'h30;
   localparam logic [7:0]  SYSREF_CAL_RESET    = 8'h00;
   localparam int          DIGITAL_QUIET_BIT   = 5;
   localparam int          CLOCK_QUIET_BIT     = 4;
   localparam int          INIT_DONE_BIT       = 0;
   localparam int          CAL_ENABLE_BIT      = 0;
   localparam int          VARIANT_WIDTH       = 5;
endpackage
`default_nettype wire

//--- rise_detect.sv
`timescale 1ns/1ps
`default_nettype none
module rise_detect (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rstn,
   // Level in, pulse out.
   input  wire logic level,
   output logic      rise
);
   logic prev;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev <= 1'h0;
      end else begin
         prev <= level;
      end
   end

   assign rise = level & ~prev;
endmodule
`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock.
   input  wire logic        clk,
   // Register access; released address and data carry the inverse and both strobes drop low, so stale values never look live.
   output logic             reg_wr    = 1'h0,
   output logic             reg_rd    = 1'h0,
   output logic      [11:0] reg_addr  = 12'h0,
   output logic      [15:0] reg_wdata = 16'h0,
   input  wire logic [15:0] reg_rdata
);
   task automatic xfer(input logic w, logic [11:0] a, logic [15:0] d, output logic [15:0] q);
      @(negedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(negedge clk);
      q = reg_rdata;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
   endtask
endmodule
`default_nettype wire

//--- tb_misc_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_misc_status_config_regs;
   logic        clk = 1'h0, rstn = 1'h0, init_done_in = 1'h0, reg_wr, reg_rd, dq, cq, cs, ads;
   logic [11:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, phase, q;
   int          err_count = 0, samples_checked = 0;
   wire logic [15:0] ctl = {12'h0, dq, cq, cs, ads};
   always #2.5 clk = ~clk;
   misc_status_config_regs #(.VARIANT_CODE(5'h15)) misc_status_config_regs_i (.clk(clk),
      .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .init_done_in(init_done_in), .nco_phase_chan_b_preset3(phase),
      .digital_rail_quieting(dq), .clock_rail_quieting(cq), .cal_start(cs),
      .auto_delay_select(ads));
   host_model host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      err_count += int'(got !== exp);
      if (got !== exp) $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
   endtask
   task automatic give_verdict;
      $display("%0d checks, %0d mismatches", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (400) @(posedge clk);
      err_count++;
      give_verdict;
   end
   // The startup flag lags its input, so polling is bounded rather than a fixed wait.
   task automatic poll_ready;
      q = 16'h0000;
      for (int i = 0; i < 9 && q !== 16'h0001; i++) host_model_i.xfer(1'h0, 12'h270, 16'h0, q);
      check(q, 16'h0001);
   endtask
   task automatic t_bank;
      check(ctl, 16'h000C);
      check(phase, 16'h0);
      init_done_in = 1'h1;
      poll_ready;
      host_model_i.xfer(1'h1, 12'h25C, 16'hA5C3, q);
      check(phase, 16'hA5C3);
      host_model_i.xfer(1'h1, 12'h297, 16'hFFFF, q);
      host_model_i.xfer(1'h0, 12'h297, 16'h0, q);
      check(q, 16'h15);
      host_model_i.xfer(1'h1, 12'h2A2, 16'h10, q);
      host_model_i.xfer(1'h1, 12'h2B0, 16'hFF, q);
      check(ctl, 16'h7);
      @(negedge clk);
      check(ctl, 16'h5);
      $display("t_bank finished");
   endtask
   task automatic t_readback;
      host_model_i.xfer(1'h0, 12'h25C, 16'h0000, q);
      check(q, 16'hA5C3);
      host_model_i.xfer(1'h0, 12'h2A2, 16'h0000, q);
      check(q, 16'h0010);
      host_model_i.xfer(1'h0, 12'h2B0, 16'h0000, q);
      check(q, 16'h0001);
      host_model_i.xfer(1'h1, 12'h270, 16'h0000, q);
      host_model_i.xfer(1'h0, 12'h270, 16'h0000, q);
      check(q, 16'h0001);
      host_model_i.xfer(1'h0, 12'h2B1, 16'h0000, q);
      check(q, 16'h0000);
      host_model_i.xfer(1'h1, 12'h2B0, 16'h0000, q);
      check(ctl, 16'h0004);
      host_model_i.xfer(1'h1, 12'h2B0, 16'h0001, q);
      check(ctl, 16'h0007);
      host_model_i.xfer(1'h1, 12'h2B0, 16'h0001, q);
      check(ctl, 16'h0005);
      $display("t_readback finished");
   endtask
   // A device reset restarts initialization, so the host polls the flag again.
   task automatic t_reset;
      @(negedge clk);
      rstn = 1'h0;
      init_done_in = 1'h0;
      @(negedge clk);
      check(ctl, 16'h000C);
      check(reg_rdata, 16'h0000);
      check(phase, 16'h0000);
      repeat (4) @(negedge clk);
      rstn = 1'h1;
      repeat (3) @(negedge clk);
      init_done_in = 1'h1;
      poll_ready;
      host_model_i.xfer(1'h0, 12'h2A2, 16'h0000, q);
      check(q, 16'h0030);
      host_model_i.xfer(1'h0, 12'h2B0, 16'h0000, q);
      check(q, 16'h0000);
      host_model_i.xfer(1'h0, 12'h25C, 16'h0000, q);
      check(q, 16'h0000);
      $display("t_reset finished");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'h1;
      t_bank;
      t_readback;
      t_reset;
      give_verdict;
   end
endmodule
`default_nettype wire
